/* File: core/ssp_top.sv */
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Screen-one height is 10 bits: high reg bits 1:0 over low reg.
// - Lines 0..n show screen one, lines n+1 onward show screen two.
// - Screen-two lines fetch from screen-two start, others from screen-one.
// - Three tables, red, green, blue, each 256 entries of 4 bits.
// - An 8-bit pointer register selects the table index accessed.
// - Writing the pointer register selects red of the written index.
// - Each data access steps red, green, blue, then next index red.
// - Data access acts on the entry the pointer currently selects.
// - A triple is committed only when its blue part is written.
// - Screen-one start is a word address into display memory.
module ssp_top #(
  parameter int ADR_W = 19,
  parameter int HGT_W = 10,
  parameter int IDX_W = 8,
  parameter int ENT_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [HGT_W-1:0] line_i,
  input wire logic [15:0] scr1_start_i,
  input wire logic [15:0] scr2_start_i,
  output logic screen_two_o,
  output logic [15:0] fetch_base_o,
  input wire logic [IDX_W-1:0] pix_index_i,
  output logic [3*ENT_W-1:0] pix_rgb_o
);

  ssp_lut_if #(.IDX_W(IDX_W), .ENT_W(ENT_W)) lut_bus ();

  ssp_lut #(.IDX_W(IDX_W), .ENT_W(ENT_W)) u_lut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lut(lut_bus.mem)
  );

  // ==========================================================
  // Address decode
  function automatic logic reg_hit(input logic [16:0] idx);
    return wb_adr_i[ADR_W-1:2] == idx[ADR_W-3:0];
  endfunction

  logic req;
  logic wr_lo;
  logic hit_lo;
  logic hit_hi;
  logic hit_ptr;
  logic hit_dat;
  logic dat_acc;

  // New request only while ack is low, so each cycle acts once
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr_lo = req && wb_we_i && wb_sel_i[0];
    hit_lo = reg_hit(ssp_pkg::IDX_HEIGHT_LO);
    hit_hi = reg_hit(ssp_pkg::IDX_HEIGHT_HI);
    hit_ptr = reg_hit(ssp_pkg::IDX_PTR);
    hit_dat = reg_hit(ssp_pkg::IDX_DATA);
    dat_acc = hit_dat && (wr_lo || (req && !wb_we_i));
  end

  // ==========================================================
  // Register state
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [HGT_W-1:0] hgt_q, hgt_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  ssp_pkg::ssp_comp_e comp_q, comp_d;
  logic [ENT_W-1:0] red_sh_q, red_sh_d;
  logic [ENT_W-1:0] grn_sh_q, grn_sh_d;
  logic [7:0] rd_val;

  // Next values: one-cycle ack, read mux, pointer walk, shadow capture
  always_comb begin
    ack_d = req;
    hgt_d = hgt_q;
    idx_d = idx_q;
    comp_d = comp_q;
    red_sh_d = red_sh_q;
    grn_sh_d = grn_sh_q;
    rd_val = 8'h00; // Unmapped addresses read zero and still ack
    if (hit_lo) begin
      rd_val = hgt_q[7:0];
    end else if (hit_hi) begin
      rd_val = {6'h00, hgt_q[HGT_W-1:8]};
    end else if (hit_ptr) begin
      rd_val = idx_q;
    end else if (hit_dat) begin
      rd_val = {lut_bus.bus_dat, 4'h0};
    end
    dat_d = (req && !wb_we_i) ? {24'h000000, rd_val} : 32'h00000000;
    if (wr_lo && hit_lo) begin
      hgt_d[7:0] = wb_dat_i[7:0];
    end
    if (wr_lo && hit_hi) begin
      hgt_d[HGT_W-1:8] = wb_dat_i[ssp_pkg::HI_MSB:0];
    end
    if (wr_lo && hit_ptr) begin
      idx_d = wb_dat_i[IDX_W-1:0];
      comp_d = ssp_pkg::SSP_RED;
    end
    if (dat_acc) begin
      if (wb_we_i && comp_q == ssp_pkg::SSP_RED) begin
        red_sh_d = wb_dat_i[ssp_pkg::DATA_LSB +: ENT_W];
      end
      if (wb_we_i && comp_q == ssp_pkg::SSP_GREEN) begin
        grn_sh_d = wb_dat_i[ssp_pkg::DATA_LSB +: ENT_W];
      end
      case (comp_q)
        ssp_pkg::SSP_RED: comp_d = ssp_pkg::SSP_GREEN;
        ssp_pkg::SSP_GREEN: comp_d = ssp_pkg::SSP_BLUE;
        ssp_pkg::SSP_BLUE: begin
          comp_d = ssp_pkg::SSP_RED;
          idx_d = idx_q + 1'b1; // wraps from 255 to 0
        end
        default: comp_d = ssp_pkg::SSP_RED;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      hgt_q <= ssp_pkg::HEIGHT_RST;
      idx_q <= ssp_pkg::PTR_RST;
      comp_q <= ssp_pkg::SSP_RED;
      red_sh_q <= '0;
      grn_sh_q <= '0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      hgt_q <= hgt_d;
      idx_q <= idx_d;
      comp_q <= comp_d;
      red_sh_q <= red_sh_d;
      grn_sh_q <= grn_sh_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // Table ports: commit waits for blue so partial writes stay hidden
  assign lut_bus.wr_en = dat_acc && wb_we_i
                         && comp_q == ssp_pkg::SSP_BLUE;
  assign lut_bus.wr_idx = idx_q;
  assign lut_bus.wr_r = red_sh_q;
  assign lut_bus.wr_g = grn_sh_q;
  assign lut_bus.wr_b = wb_dat_i[ssp_pkg::DATA_LSB +: ENT_W];
  assign lut_bus.bus_idx = idx_q;
  assign lut_bus.bus_comp = comp_q;
  assign lut_bus.pix_idx = pix_index_i;
  assign pix_rgb_o = lut_bus.pix_rgb;

  // ==========================================================
  // Split screen select for the refresh path
  logic scr2_q, scr2_d;
  logic [15:0] base_q, base_d;

  // Height at or above panel size keeps every line in screen one
  always_comb begin
    scr2_d = line_i > hgt_q;
    base_d = scr2_d ? scr2_start_i : scr1_start_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scr2_q <= 1'b0;
      base_q <= 16'h0000;
    end else begin
      scr2_q <= scr2_d;
      base_q <= base_d;
    end
  end

  assign screen_two_o = scr2_q;
  assign fetch_base_o = base_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held longer than one cycle");
  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Request not answered next cycle");
  a_height_high: assert property (wr_lo && hit_hi |=>
    hgt_q[9:8] == $past(wb_dat_i[1:0]))
    else $error("Height high bits not stored");
  a_ptr_sets_red: assert property (wr_lo && hit_ptr |=>
    comp_q == ssp_pkg::SSP_RED && idx_q == $past(wb_dat_i[7:0]))
    else $error("Pointer write did not select red");
  a_ptr_steps: assert property (dat_acc
    && comp_q == ssp_pkg::SSP_RED
    |=> comp_q == ssp_pkg::SSP_GREEN ##0 idx_q == $past(idx_q))
    else $error("Pointer did not step to green");
  a_ptr_wraps: assert property (dat_acc
    && comp_q == ssp_pkg::SSP_BLUE
    && idx_q == ssp_pkg::IDX_LAST |=> idx_q == 8'h00
    && comp_q == ssp_pkg::SSP_RED)
    else $error("Pointer did not wrap to red of index 0");
  a_data_read: assert property (req && !wb_we_i && hit_dat |=>
    wb_dat_o == {24'h000000, $past(lut_bus.bus_dat), 4'h0})
    else $error("Data port read wrong entry or layout");
  // Sampled reset in the antecedent: the release edge still shows reset
  a_split_line: assert property (!rst_i && line_i <= hgt_q
    |=> !screen_two_o && fetch_base_o == $past(scr1_start_i))
    else $error("Upper line not taken from screen one");
  a_split_lower: assert property (!rst_i && line_i > hgt_q
    |=> screen_two_o && fetch_base_o == $past(scr2_start_i))
    else $error("Lower line not taken from screen two");
  a_green_shadow: assert property (dat_acc && wb_we_i
    && comp_q == ssp_pkg::SSP_GREEN |=> !lut_bus.wr_en
    && grn_sh_q == $past(wb_dat_i[7:4]))
    else $error("Green write not held back in shadow");

endmodule
`default_nettype wire

/* File: core/ssp_pkg.sv */
`default_nettype none
package ssp_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [16:0] IDX_HEIGHT_LO = 17'h1FFF2;
  localparam logic [16:0] IDX_HEIGHT_HI = 17'h1FEF3;
  localparam logic [16:0] IDX_PTR = 17'h1FFF5;
  localparam logic [16:0] IDX_DATA = 17'h1FFF7;

  // ==========================================================
  // Field layout and reset values
  localparam int HI_MSB = 1;         // Height bits 9:8 sit in high reg 1:0
  localparam int DATA_LSB = 4;       // Entry value sits in data bits 7:4
  localparam logic [9:0] HEIGHT_RST = 10'h3FF;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] IDX_LAST = 8'hFF;

  // ==========================================================
  // Colour component that the pointer selects
  typedef enum logic [1:0] {
    SSP_RED,
    SSP_GREEN,
    SSP_BLUE
  } ssp_comp_e;

endpackage
`default_nettype wire

/* File: core/ssp_lut_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ssp_lut_if #(
  parameter int IDX_W = 8,
  parameter int ENT_W = 4
);
  // ==========================================================
  // Commit port, bus read port and refresh read port
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [ENT_W-1:0] wr_r;
  logic [ENT_W-1:0] wr_g;
  logic [ENT_W-1:0] wr_b;
  logic [IDX_W-1:0] bus_idx;
  ssp_pkg::ssp_comp_e bus_comp;
  logic [ENT_W-1:0] bus_dat;
  logic [IDX_W-1:0] pix_idx;
  logic [3*ENT_W-1:0] pix_rgb;

  modport ctl (
    output wr_en, wr_idx, wr_r, wr_g, wr_b, bus_idx, bus_comp, pix_idx,
    input bus_dat, pix_rgb
  );
  modport mem (
    input wr_en, wr_idx, wr_r, wr_g, wr_b, bus_idx, bus_comp, pix_idx,
    output bus_dat, pix_rgb
  );
endinterface
`default_nettype wire

/* File: core/ssp_lut.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_lut #(
  parameter int IDX_W = 8,
  parameter int ENT_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ssp_lut_if.mem lut
);
  localparam int DEPTH = 1 << IDX_W;

  // ==========================================================
  // Storage: one table per colour
  logic [ENT_W-1:0] red_q [DEPTH];
  logic [ENT_W-1:0] grn_q [DEPTH];
  logic [ENT_W-1:0] blu_q [DEPTH];
  logic [3*ENT_W-1:0] pix_d;
  logic [3*ENT_W-1:0] pix_q;

  // Whole triple lands in one edge, so refresh never sees half an entry
  always_ff @(posedge clk_i) begin
    if (lut.wr_en) begin
      red_q[lut.wr_idx] <= lut.wr_r;
      grn_q[lut.wr_idx] <= lut.wr_g;
      blu_q[lut.wr_idx] <= lut.wr_b;
    end
  end

  // Bus read of the entry under the pointer
  always_comb begin
    case (lut.bus_comp)
      ssp_pkg::SSP_RED: lut.bus_dat = red_q[lut.bus_idx];
      ssp_pkg::SSP_GREEN: lut.bus_dat = grn_q[lut.bus_idx];
      ssp_pkg::SSP_BLUE: lut.bus_dat = blu_q[lut.bus_idx];
      default: lut.bus_dat = '0;
    endcase
  end

  // Refresh path colour lookup, registered
  always_comb begin
    pix_d = {red_q[lut.pix_idx], grn_q[lut.pix_idx], blu_q[lut.pix_idx]};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_q <= '0;
    end else begin
      pix_q <= pix_d;
    end
  end

  assign lut.pix_rgb = pix_q;

  // ==========================================================
  // Checks
  a_commit_triple: assert property (
    @(posedge clk_i) disable iff (rst_i)
    lut.wr_en |=> red_q[$past(lut.wr_idx)] == $past(lut.wr_r)
      && grn_q[$past(lut.wr_idx)] == $past(lut.wr_g)
      && blu_q[$past(lut.wr_idx)] == $past(lut.wr_b))
    else $error("Table triple not committed");

endmodule
`default_nettype wire

/* File: testbench/ssp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_top_tb;
  // ==========================================================
  // Stimulus and observed signals
  localparam logic [16:0] HLO = ssp_pkg::IDX_HEIGHT_LO;
  localparam logic [16:0] HHI = ssp_pkg::IDX_HEIGHT_HI;
  localparam logic [16:0] PTR = ssp_pkg::IDX_PTR;
  localparam logic [16:0] DAT = ssp_pkg::IDX_DATA;
  localparam logic [15:0] BASE1 = 16'h1234;
  localparam logic [15:0] BASE2 = 16'hABCD;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [18:0] wb_adr_i = 19'h00000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [9:0] line_i = 10'h000;
  logic screen_two_o;
  logic [15:0] fetch_base_o;
  logic [7:0] pix_index_i = 8'h00;
  logic [11:0] pix_rgb_o;
  int num_errors = 0;
  int n_compared = 0;
  int i;
  logic [15:0] junk;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  ssp_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .line_i(line_i), .scr1_start_i(BASE1), .scr2_start_i(BASE2),
    .screen_two_o(screen_two_o), .fetch_base_o(fetch_base_o),
    .pix_index_i(pix_index_i), .pix_rgb_o(pix_rgb_o)
  );

  // ==========================================================
  // Verdict, reached from the main sequence or a bus timeout
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // ==========================================================
  // Classic single Wishbone cycle; the wait on ack is bounded
  task automatic wb(input logic we, input logic [16:0] idx,
                    input logic [7:0] wd, input logic [3:0] sel,
                    output logic [15:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      $display("ERROR bus ack expected 1 seen %b", wb_ack_o);
      num_errors++;
      end_of_test();
    end
    rdat = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [16:0] idx, input logic [7:0] wd);
    logic [15:0] dummy;
    wb(1'b1, idx, wd, 4'hF, dummy);
  endtask

  // Upper read bits must be zero, so 16 bits are compared
  task automatic rd(input logic [16:0] idx, input logic [7:0] exp,
                    input string what);
    logic [15:0] got;
    wb(1'b0, idx, 8'h00, 4'hF, got);
    chk(what, {8'h00, exp}, got);
  endtask

  // Refresh path outputs are registered: look two edges later
  task automatic scan(input logic [9:0] ln, input logic two);
    @(posedge clk_i);
    line_i <= ln;
    repeat (2) @(posedge clk_i);
    chk("screen two", {15'h0000, two}, {15'h0000, screen_two_o});
    chk("fetch base", two ? BASE2 : BASE1, fetch_base_o);
  endtask

  task automatic look(input logic [7:0] idx, input logic [11:0] exp);
    @(posedge clk_i);
    pix_index_i <= idx;
    repeat (2) @(posedge clk_i);
    chk("pixel rgb", {4'h0, exp}, {4'h0, pix_rgb_o});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(HLO, 8'hFF, "height low");
    rd(HHI, 8'h03, "height high");
    rd(PTR, 8'h00, "pointer");
    rd(17'h1FFF0, 8'h00, "unmapped");
    // Reset height is at least any panel size, as no-split use needs
    scan(10'h3FF, 1'b0);
    $display("Test reset values done");
    // Split at the example height, then a height using the high bits
    wr(HLO, 8'hCE);
    wr(HHI, 8'h00);
    rd(HLO, 8'hCE, "height low");
    // A write without byte lane 0 must leave the register alone
    wb(1'b1, HLO, 8'h77, 4'hE, junk);
    rd(HLO, 8'hCE, "height low masked");
    scan(10'h0CE, 1'b0);
    scan(10'h0CF, 1'b1);
    // Bits above 1:0 of the high byte are dropped: height becomes 0x105
    wr(HHI, 8'hFD);
    wr(HLO, 8'h05);
    rd(HHI, 8'h01, "height high");
    scan(10'h105, 1'b0);
    scan(10'h106, 1'b1);
    $display("Test split screen done");
    // Three triples across the index wrap; low nibble must be dropped
    wr(PTR, 8'hFE);
    for (i = 0; i < 9; i++) begin
      wr(DAT, {4'(i + 1), 4'hF});
    end
    rd(PTR, 8'h01, "pointer wrap");
    look(8'hFE, 12'h123);
    look(8'hFF, 12'h456);
    look(8'h00, 12'h789);
    wr(PTR, 8'hFF);
    for (i = 0; i < 4; i++) begin
      rd(DAT, {4'(i + 4), 4'h0}, "table data");
    end
    $display("Test table stepping done");
    // Red and green alone must not reach the table
    wr(PTR, 8'h00);
    wr(DAT, 8'hA0);
    wr(DAT, 8'hB0);
    look(8'h00, 12'h789);
    rd(PTR, 8'h00, "pointer");
    wr(PTR, 8'h00);
    wr(DAT, 8'hC0);
    wr(DAT, 8'hD0);
    wr(DAT, 8'hE0);
    look(8'h00, 12'hCDE);
    $display("Test partial triple done");
    end_of_test();
  end
endmodule
`default_nettype wire
